// ===== core/sac_sequencer.sv
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module sac_sequencer (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic [1:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  input  wire logic                 flag_sel,
  output logic      [7:0]           reg_rdata,
  input  wire logic                 special_trigger,
  output logic                      trigger_timer_clear,
  input  wire logic                 sleep_req,
  input  wire logic                 conversion_irq_enable,
  output logic                      wake_req,
  output logic                      conversion_done_flag,
  input  wire logic                 comparator_in,
  output sac_pkg::sac_analog_s      analog
);
  import sac_pkg::*;

  typedef struct packed {
    logic        justify;
    logic        neg_ref;
    logic        pos_ref;
    logic [2:0]  chan;
    logic        busy;
    logic        enable;
    logic [2:0]  clk_sel;
    logic [7:0]  res_hi;
    logic [7:0]  res_lo;
    logic        done;
    sac_state_e  state;
    logic [7:0]  div_cnt;
    logic [3:0]  periods;
    logic [9:0]  sar;
    logic [9:0]  bitmask;
    logic        trg_s1;
    logic        trg_s2;
    logic        trg_d;
    logic        slp_s1;
    logic        slp_s2;
    logic        irq_s1;
    logic        irq_s2;
    logic        rc_run;
    logic        wake;
    logic        tclr;
    logic [7:0]  rdata;
    sac_analog_s ana;
  } sac_state_s;

  sac_state_s r;
  sac_state_s next_r;

  // System clock divider per clock select code; 0 means RC source
  function automatic logic [7:0] div_of(input logic [2:0] sel);
    case (sel)
      3'b000:  div_of = 8'h02;
      3'b001:  div_of = 8'h08;
      3'b010:  div_of = 8'h20;
      3'b100:  div_of = 8'h04;
      3'b101:  div_of = 8'h10;
      3'b110:  div_of = 8'h40;
      default: div_of = 8'h00;
    endcase
  endfunction

  function automatic logic is_rc(input logic [2:0] sel);
    is_rc = (sel[1:0] == 2'b11);
  endfunction

  logic [7:0] period_len;
  logic       tick;
  logic [9:0] conv_res;
  logic       sleeping;
  logic       irq_on;
  logic       trig_rise;
  logic       sw_start;
  logic       sw_clear;

  // Next state: registers, sequencer and read port
  always_comb begin
    next_r = r;
    next_r.trg_s1 = special_trigger;
    next_r.trg_s2 = r.trg_s1;
    next_r.trg_d  = r.trg_s2;
    next_r.slp_s1 = sleep_req;
    next_r.slp_s2 = r.slp_s1;
    next_r.irq_s1 = conversion_irq_enable;
    next_r.irq_s2 = r.irq_s1;
    next_r.wake   = 1'b0;
    next_r.tclr   = 1'b0;
    sleeping  = r.slp_s2;
    irq_on    = r.irq_s2;
    trig_rise = r.trg_s2 & ~r.trg_d;
    // RC source modelled as fixed-length period from the system clock
    period_len = is_rc(r.clk_sel) ? 8'(SAC_RC_DIV) : div_of(r.clk_sel);
    tick = (r.div_cnt == period_len - 8'h01);
    next_r.div_cnt = tick ? 8'h00 : r.div_cnt + 8'h01;
    conv_res = r.sar;
    sw_start = 1'b0;
    sw_clear = 1'b0;

    // Register writes
    if (reg_write) begin
      case (reg_addr)
        SAC_ADDR_CTRL0: begin
          next_r.justify = reg_wdata[SAC_C0_JUSTIFY];
          next_r.neg_ref = reg_wdata[SAC_C0_NEGREF];
          next_r.pos_ref = reg_wdata[SAC_C0_POSREF];
          next_r.chan    = reg_wdata[SAC_C0_CHAN_LO +: 3];
          next_r.enable  = reg_wdata[SAC_C0_ENABLE];
          sw_start = reg_wdata[SAC_C0_BUSY] & ~r.busy;
          sw_clear = ~reg_wdata[SAC_C0_BUSY] & r.busy;
        end
        SAC_ADDR_CTRL1: next_r.clk_sel = reg_wdata[SAC_C1_CLK_LO +: 3];
        SAC_ADDR_RES_HI: next_r.res_hi = reg_wdata;
        default: begin
          // Flag alias shares the low-result index, picked by flag_sel
          if (flag_sel) begin
            if (!reg_wdata[0]) next_r.done = 1'b0;
          end else begin
            next_r.res_lo = reg_wdata;
          end
        end
      endcase
    end

    // Hardware trigger sets busy like a software start
    if (trig_rise && r.enable && !r.busy) begin
      sw_start = 1'b1;
      next_r.tclr = 1'b1;
    end
    if (sw_start) next_r.busy = 1'b1;

    // Conversion sequencer
    case (r.state)
      SAC_IDLE: begin
        // A start left pending by an abort gap is taken up here
        if ((sw_start || r.busy) && r.enable) begin
          next_r.sar     = 10'h000;
          next_r.bitmask = 10'h200;
          next_r.periods = 4'h0;
          next_r.div_cnt = 8'h00;
          // RC start waits one instruction so a sleep can execute
          next_r.periods = is_rc(r.clk_sel) ? 4'(SAC_INSTR_CYCLES) : 4'h0;
          next_r.state   = is_rc(r.clk_sel) ? SAC_DELAY : SAC_CONV;
          next_r.rc_run  = is_rc(r.clk_sel);
        end else if (sw_start || r.busy) begin
          next_r.busy = 1'b0;
        end
      end
      SAC_DELAY: begin
        next_r.periods = r.periods - 4'h1;
        next_r.div_cnt = 8'h00;
        if (r.periods == 4'h1) next_r.state = SAC_CONV;
      end
      SAC_CONV: begin
        if (tick) begin
          next_r.periods = r.periods + 4'h1;
          // First period samples; then one bit per period from the top
          // Comparator is same-clock logic: a sync stage would not fit
          // the shortest period of two system cycles
          if (r.periods != 4'h0) begin
            next_r.sar = comparator_in ? (r.sar | r.bitmask) : r.sar;
            next_r.bitmask = r.bitmask >> 1;
          end
          if (r.periods == 4'(SAC_CONV_PERIODS - 1)) begin
            conv_res = comparator_in ? (r.sar | r.bitmask) : r.sar;
            next_r.busy  = 1'b0;
            next_r.done  = 1'b1;
            if (r.justify) begin
              next_r.res_hi = {6'h00, conv_res[9:8]};
              next_r.res_lo = conv_res[7:0];
            end else begin
              next_r.res_hi = conv_res[9:2];
              next_r.res_lo = {conv_res[1:0], 6'h00};
            end
            if (sleeping && irq_on) next_r.wake = 1'b1;
            next_r.state = (sleeping && !irq_on) ? SAC_PARKED
                                                 : SAC_IDLE;
          end
        end
      end
      SAC_ABORT: begin
        if (tick) begin
          next_r.periods = r.periods + 4'h1;
          if (r.periods == 4'(SAC_ABORT_PERIODS - 1))
            next_r.state = SAC_IDLE;
        end
      end
      SAC_PARKED: begin
        // Powered down after sleep; enable still reads set
        if (!sleeping) next_r.state = SAC_IDLE;
      end
      default: next_r.state = SAC_IDLE;
    endcase

    // Abort paths: software clear, sleep without RC, disable
    if (r.state == SAC_CONV || r.state == SAC_DELAY) begin
      if (sw_clear) begin
        next_r.busy = 1'b0;
        next_r.state = SAC_ABORT;
        next_r.periods = 4'h0;
        next_r.div_cnt = 8'h00;
      end else if (sleeping && !r.rc_run) begin
        next_r.busy = 1'b0;
        next_r.state = SAC_PARKED;
      end else if (!r.enable) begin
        next_r.busy = 1'b0;
        next_r.state = SAC_IDLE;
      end
    end else if (sleeping && r.state == SAC_IDLE && !r.busy) begin
      next_r.state = SAC_PARKED;
    end
    if (sw_clear) next_r.busy = 1'b0;

    // Done flag: a completion in the clearing cycle wins
    if (r.state == SAC_CONV && tick &&
        r.periods == 4'(SAC_CONV_PERIODS - 1))
      next_r.done = 1'b1;

    // Analog side drive
    next_r.ana.powered = next_r.enable &&
                         next_r.state != SAC_PARKED;
    next_r.ana.sample  = next_r.state != SAC_CONV ||
                         next_r.periods == 4'h0;
    next_r.ana.channel = next_r.chan;
    next_r.ana.neg_ref_ext = next_r.neg_ref;
    next_r.ana.pos_ref_ext = next_r.pos_ref;
    next_r.ana.trial   = next_r.sar | next_r.bitmask;

    // Read data, valid the cycle after the strobe
    next_r.rdata = 8'h00;
    if (reg_read) begin
      case (reg_addr)
        SAC_ADDR_CTRL0: next_r.rdata = {r.justify, r.neg_ref, r.pos_ref,
                                        r.chan, r.busy, r.enable};
        SAC_ADDR_CTRL1: next_r.rdata = {1'b0, r.clk_sel, 4'h0}
                                       & SAC_CTRL1_MASK;
        SAC_ADDR_RES_HI: next_r.rdata = r.res_hi;
        default: next_r.rdata = flag_sel ? {7'h00, r.done} : r.res_lo;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
      r.state <= SAC_IDLE;
      r.clk_sel <= SAC_CLKSEL_RST;
      {r.justify, r.neg_ref, r.pos_ref, r.chan, r.busy, r.enable}
        <= SAC_CTRL0_RST;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata            = r.rdata;
  assign trigger_timer_clear  = r.tclr;
  assign wake_req             = r.wake;
  assign conversion_done_flag = r.done;
  assign analog               = r.ana;

endmodule

// ===== core/sac_pkg.sv
package sac_pkg;

  // Register indices on the plain register port
  localparam logic [1:0] SAC_ADDR_CTRL0   = 2'h0;
  localparam logic [1:0] SAC_ADDR_CTRL1   = 2'h1;
  localparam logic [1:0] SAC_ADDR_RES_HI  = 2'h2;
  localparam logic [1:0] SAC_ADDR_RES_LO  = 2'h3;
  localparam logic [1:0] SAC_ADDR_FLAGS   = 2'h3;

  // Control zero field positions
  localparam int SAC_C0_JUSTIFY = 7;
  localparam int SAC_C0_NEGREF  = 6;
  localparam int SAC_C0_POSREF  = 5;
  localparam int SAC_C0_CHAN_LO = 2;
  localparam int SAC_C0_BUSY    = 1;
  localparam int SAC_C0_ENABLE  = 0;
  // Control one field position
  localparam int SAC_C1_CLK_LO  = 4;

  // Reset values and control one read mask
  localparam logic [7:0] SAC_CTRL0_RST = 8'h00;
  localparam logic [2:0] SAC_CLKSEL_RST = 3'h0;
  localparam logic [7:0] SAC_CTRL1_MASK = 8'h70;

  // Timing: periods per conversion and abort gap, system clock
  localparam int    SAC_CONV_PERIODS  = 11;
  localparam int    SAC_ABORT_PERIODS = 2;
  localparam int    SAC_INSTR_CYCLES  = 4;
  localparam real   SAC_CLK_NS        = 8.0;
  localparam real   SAC_RC_PERIOD_NS  = 2000.0;
  localparam int    SAC_RC_DIV =
      (SAC_RC_PERIOD_NS / SAC_CLK_NS) < 1.0 ? 1 :
      int'($ceil(SAC_RC_PERIOD_NS / SAC_CLK_NS));

  typedef enum logic [2:0] {
    SAC_IDLE   = 3'b000,
    SAC_DELAY  = 3'b001,
    SAC_CONV   = 3'b010,
    SAC_ABORT  = 3'b011,
    SAC_PARKED = 3'b100
  } sac_state_e;

  // Analog side control bundle
  typedef struct packed {
    logic       powered;
    logic       sample;
    logic [2:0] channel;
    logic       neg_ref_ext;
    logic       pos_ref_ext;
    logic [9:0] trial;
  } sac_analog_s;

endpackage

// ===== verification/sac_chk.sv
`timescale 1ns/1ps
module sac_chk (
  input wire logic                 clock,
  input wire logic                 rst,
  input wire logic [1:0]           reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic                 reg_write,
  input wire logic                 reg_read,
  input wire logic                 flag_sel,
  input wire logic [7:0]           reg_rdata,
  input wire logic                 special_trigger,
  input wire logic                 trigger_timer_clear,
  input wire logic                 sleep_req,
  input wire logic                 conversion_irq_enable,
  input wire logic                 wake_req,
  input wire logic                 conversion_done_flag,
  input wire logic                 comparator_in,
  input wire sac_pkg::sac_analog_s analog
);
  import sac_pkg::*;
  logic [7:0] c0;
  // Shadow of control zero, its fields are not visible at the ports
  always_ff @(posedge clock) begin
    if (rst) begin
      c0 <= 8'h00;
    end else if (reg_write && reg_addr == SAC_ADDR_CTRL0) begin
      c0 <= reg_wdata;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Control zero write, then one quiet cycle so the shadow is settled
  sequence s_c0_wr;
    reg_write && reg_addr == SAC_ADDR_CTRL0 ##1 !reg_write;
  endsequence
  AST_RD_IDLE: assert property (
    !$past(reg_read) |-> reg_rdata == 8'h00) else $error("stray read data");
  AST_C1_ZERO: assert property (
    $past(reg_read) && $past(reg_addr) == SAC_ADDR_CTRL1
    |-> (reg_rdata & ~SAC_CTRL1_MASK) == 8'h00) else $error("ctrl1 pad set");
  AST_TRIG: assert property (
    trigger_timer_clear |-> $past(special_trigger, 3) ##1 !trigger_timer_clear)
    else $error("timer clear pulse wrong");
  AST_WAKE: assert property (
    wake_req |-> $past(sleep_req, 4) && conversion_irq_enable
    ##1 !wake_req && conversion_done_flag) else $error("bad wake pulse");
  AST_DONE_HOLD: assert property (
    conversion_done_flag && !(reg_write && flag_sel && !reg_wdata[0]
    && reg_addr == SAC_ADDR_FLAGS) |=> conversion_done_flag)
    else $error("done flag lost");
  AST_FIELDS: assert property (
    s_c0_wr |=> analog.channel == c0[4:2] && analog.neg_ref_ext == c0[6]
    && analog.pos_ref_ext == c0[5]) else $error("analog fields wrong");
  AST_OFF: assert property (
    s_c0_wr ##0 !c0[0] |=> !analog.powered) else $error("powered while off");
  AST_RESET: assert property (disable iff (1'b0)
    rst |=> reg_rdata == 8'h00 && !conversion_done_flag && !analog.powered)
    else $error("outputs not cleared by reset");
endmodule

bind sac_sequencer sac_chk sac_chk_inst (.*);

// ===== verification/sac_comp_model.sv
`timescale 1ns/1ps
module sac_comp_model (
  input  wire logic                 clock,
  input  wire sac_pkg::sac_analog_s analog,
  input  wire logic [9:0]           level,
  output logic                      comparator_in
);
  import sac_pkg::*;
  logic junk = 1'b0;
  // Unpowered comparator wanders, so a stale decision cannot pass
  always_ff @(posedge clock) begin
    junk <= ~junk;
  end
  // Input sits half a step above level: trials up to level read high
  assign comparator_in = analog.powered ?
                         level >= analog.trial : junk;
endmodule

// ===== verification/sac_sequencer_tb_top.sv
`timescale 1ns/1ps
module sac_sequencer_tb_top;
  import sac_pkg::*;
  typedef struct {
    logic [7:0] c1, c0, hi, lo;
    logic [9:0] lv;
    int         dv;
  } sac_row_s;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  reg_addr = 2'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0, reg_read = 1'b0, flag_sel = 1'b0;
  logic        special_trigger = 1'b0, sleep_req = 1'b0;
  logic        conversion_irq_enable = 1'b0;
  logic [9:0]  level = 10'h000;
  logic [7:0]  reg_rdata;
  logic        trigger_timer_clear, wake_req;
  logic        conversion_done_flag, comparator_in;
  sac_analog_s analog;
  int          miscompares = 0, n_tests = 0, clears = 0, wakes = 0;
  // Ctrl one, ctrl zero, result high, result low, level, divider
  sac_row_s    rows [6] = '{
    '{8'h8F, 8'h81, 8'h02, 8'hA5, 10'h2A5, 2},
    '{8'h9F, 8'h05, 8'hA9, 8'h40, 10'h2A5, 8},
    '{8'hAF, 8'hFD, 8'h03, 8'hFF, 10'h3FF, 32},
    '{8'hCF, 8'h4D, 8'h00, 8'h00, 10'h000, 4},
    '{8'hDF, 8'h95, 8'h01, 8'h55, 10'h155, 16},
    '{8'hEF, 8'h39, 8'h00, 8'h40, 10'h001, 64}};

  sac_sequencer sac_sequencer_inst (.*);
  sac_comp_model sac_comp_model_inst (
    .clock(clock), .analog(analog), .level(level),
    .comparator_in(comparator_in));

  initial begin
    forever #4 clock = ~clock;
  end
  // Pulse counters read the value before this edge's updates
  always @(posedge clock) begin
    clears += (trigger_timer_clear === 1'b1);
    wakes += (wake_req === 1'b1);
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d,
                    input logic f = 1'b0);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    flag_sel <= f;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdc(input logic [1:0] a, input logic [7:0] x,
                     input logic [7:0] m = 8'hFF, input logic f = 1'b0);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    flag_sel <= f;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata & m, x);
  endtask
  // Start, wait for the done flag, judge the length in cycles
  task automatic go(input logic [7:0] c0, input logic s, input int dv,
                    input int x);
    int n;
    int e;
    e = 1 + x + SAC_CONV_PERIODS * dv;
    wr(2'h0, c0 | 8'h02);
    sleep_req <= s;
    n = 0;
    while (conversion_done_flag !== 1'b1 && n < 4000) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(32'(n >= e - 1 && n <= e + 1), 32'h1);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    // Every divider code and both formats
    for (int i = 0; i < 6; i++) begin
      level <= rows[i].lv;
      wr(2'h1, rows[i].c1);
      wr(2'h0, rows[i].c0);
      repeat (4) @(posedge clock);
      wr(2'h3, 8'h00, 1'b1);
      go(rows[i].c0, 1'b0, rows[i].dv, 0);
      rdc(2'h2, rows[i].hi);
      rdc(2'h3, rows[i].lo);
      rdc(2'h0, rows[i].c0);
      rdc(2'h1, rows[i].c1 & SAC_CTRL1_MASK);
      rdc(2'h3, 8'h01, 8'h01, 1'b1);
    end
    // Busy cleared mid-run: the older result must survive
    level <= 10'h3FF;
    wr(2'h3, 8'h00, 1'b1);
    wr(2'h0, 8'h3B);
    repeat (100) @(posedge clock);
    wr(2'h0, 8'h39);
    repeat (800) @(posedge clock);
    chk(conversion_done_flag, 1'b0);
    rdc(2'h3, 8'h40);
    rdc(2'h0, 8'h39);
    // Hardware start from the compare unit
    wr(2'h1, 8'h00);
    wr(2'h0, 8'h81);
    repeat (4) @(posedge clock);
    special_trigger <= 1'b1;
    repeat (40) @(posedge clock);
    chk(32'(clears), 32'h1);
    chk(conversion_done_flag, 1'b1);
    special_trigger <= 1'b0;
    // RC clock in sleep, irq on then off, both RC codes
    for (int k = 0; k < 2; k++) begin
      wr(2'h1, k == 0 ? 8'h30 : 8'h70);
      conversion_irq_enable <= (k == 0);
      wr(2'h3, 8'h00, 1'b1);
      go(8'h81, 1'b1, SAC_RC_DIV, SAC_INSTR_CYCLES);
      repeat (4) @(posedge clock);
      chk(32'(wakes), 32'h1);
      chk(analog.powered, 1'b0);
      rdc(2'h0, 8'h81);
      sleep_req <= 1'b0;
    end
    // Divided clock: sleep aborts and parks, enable stays set
    wr(2'h3, 8'h00, 1'b1);
    wr(2'h1, 8'h60);
    wr(2'h0, 8'h83);
    repeat (50) @(posedge clock);
    sleep_req <= 1'b1;
    repeat (800) @(posedge clock);
    chk(conversion_done_flag, 1'b0);
    chk(analog.powered, 1'b0);
    rdc(2'h0, 8'h01, 8'h01);
    sleep_req <= 1'b0;
    // Start with enable low is dropped, converter stays off
    repeat (4) @(posedge clock);
    wr(2'h0, 8'h02);
    rdc(2'h0, 8'h00);
    chk(analog.powered, 1'b0);
    // Second reset while idle with enable low
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rdc(2'h0, SAC_CTRL0_RST);
    rdc(2'h1, 8'h00);
    chk(analog.sample, 1'b1);
    finish_test();
  end
  // Run needs about 10k cycles; a hang is cut off well after that
  initial begin
    #(8 * 30000);
    miscompares++;
    finish_test();
  end
endmodule
